/* hdl/dsl_defs.svh */
`ifndef DSL_DEFS_SVH
`define DSL_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DSL_CLK_HZ        50000000
`define DSL_TICK_MS       1
`define DSL_UNIT_SLOW_MS  20
`define DSL_LFSR_SEED     16'hACE1

// ----------------------------------------------------------------------------
// Addresses and function codes
// ----------------------------------------------------------------------------
`define DSL_ADDR_MAX      16'hFFEF
`define DSL_SELF_ADDR     16'hFFFC
`define DSL_NUM_MASTERS   5
`define DSL_FC_ACK        4'h0
`define DSL_FC_NACK       4'h1
`define DSL_FC_CONF_DATA  4'h3
`define DSL_FC_UNCONF     4'h4
`define DSL_FC_NOT_SUPP   4'hF

// ----------------------------------------------------------------------------
// Configuration defaults
// ----------------------------------------------------------------------------
`define DSL_DEF_NODE      16'h0001
`define DSL_DEF_MASTER    16'h0000
`define DSL_DEF_ACK_TMO   16'h0001

`endif

/* hdl/dsl_pkg.sv */
package dsl_pkg;

    typedef enum logic [2:0] {
        BAUD_38400 = 3'b000,
        BAUD_19200 = 3'b001,
        BAUD_9600  = 3'b010,
        BAUD_4800  = 3'b011,
        BAUD_2400  = 3'b100,
        BAUD_1200  = 3'b101,
        BAUD_600   = 3'b110,
        BAUD_300   = 3'b111
    } dsl_baud_t;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_EVEN = 2'b01,
        PAR_ODD  = 2'b10
    } dsl_parity_t;

    typedef enum logic [1:0] {
        STOP_1   = 2'b00,
        STOP_1P5 = 2'b01,
        STOP_2   = 2'b10
    } dsl_stop_t;

    typedef enum logic [1:0] {
        CTL_NONE  = 2'b00,
        CTL_MODEM = 2'b01,
        CTL_RS485 = 2'b10
    } dsl_control_t;

    typedef struct packed {
        logic [15:0] dest;
        logic [15:0] src;
        logic [3:0]  func;
        logic        primary;
    } dsl_rx_hdr_t;

    typedef struct packed {
        logic        secondary;
        logic [3:0]  func;
    } dsl_tx_req_t;

endpackage : dsl_pkg

/* hdl/dsl_serial_link.sv */
`timescale 1ns/10ps
`include "dsl_defs.svh"


// ----------------------------------------------------------------------------
// Stream buffer
// ----------------------------------------------------------------------------
module dsl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdPtr_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dsl_fifo

// ----------------------------------------------------------------------------
// Link layer engine
// ----------------------------------------------------------------------------
module dsl_serial_link #(
    parameter int CYC_PER_MS   = `DSL_CLK_HZ / 1000 * `DSL_TICK_MS,
    parameter bit PORT_HAS_485 = 1'b1,
    parameter int FIFO_DEPTH   = 4
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic [15:0]          nodeAddr,
    input  wire dsl_pkg::dsl_baud_t   baudSel,
    input  wire dsl_pkg::dsl_parity_t paritySel,
    input  wire dsl_pkg::dsl_stop_t   stopSel,
    input  wire dsl_pkg::dsl_control_t controlSel,
    input  wire logic                 masterValidateEn,
    input  wire logic                 selfAddrEn,
    input  wire logic [15:0]          primaryMasterAddr,
    input  wire logic [15:0]          masterAddr1,
    input  wire logic [15:0]          masterAddr2,
    input  wire logic [15:0]          masterAddr3,
    input  wire logic [15:0]          masterAddr4,
    input  wire logic                 askLinkAck,
    input  wire logic                 emitLinkSecondaryFrames,
    input  wire logic [15:0]          ackTimeout,
    input  wire logic [7:0]           retryCount,
    input  wire logic [15:0]          preTxDelay,
    input  wire logic [15:0]          maxRandomDelay,
    input  wire logic [15:0]          rtsOffDelay,
    input  wire logic [15:0]          rtsSendDelay,
    input  wire dsl_pkg::dsl_rx_hdr_t rxHdr,
    input  wire logic                 rxHdrValid,
    output logic                      rxAccept,
    output logic                      rxDrop,
    input  wire dsl_pkg::dsl_tx_req_t txReq,
    input  wire logic                 txReqValid,
    output logic                      txReqReady,
    input  wire logic [7:0]           txData,
    input  wire logic                 txLast,
    input  wire logic                 txValid,
    output logic                      txReady,
    output logic [3:0]                primaryFunc,
    output logic [15:0]               unsolDest,
    output logic                      frameDone,
    output logic                      resendReq,
    output logic                      linkFail,
    output logic                      txd,
    output logic                      rts,
    output logic                      driverEn,
    input  wire logic                 cts
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PRE    = 3'b001,
        ST_RTSUP  = 3'b010,
        ST_SEND   = 3'b011,
        ST_RTSOFF = 3'b100,
        ST_ACK    = 3'b101,
        ST_DRAIN  = 3'b110
    } dsl_state_t;

    dsl_state_t  state_r;
    logic [15:0] msCnt_r;
    logic        msTick;
    logic [20:0] waitMs_r;
    logic [15:0] lfsr_r;
    logic [2:0]  ctsSync_r;
    logic        ctsStable_r;
    logic        isModem;
    logic        is485;
    logic        confirmFrame_r;
    logic [7:0]  retryLeft_r;
    logic        inRetry_r;
    logic [15:0] halfDiv_r;
    logic [15:0] halfDiv;
    logic [4:0]  halves_r;
    logic [10:0] shift_r;
    logic        bitPhase_r;
    logic        busy_r;
    logic [8:0]  fOutData;
    logic        fOutValid;
    logic        fOutReady;
    logic        lastSent_r;
    logic [15:0] node;
    logic        destOk;
    logic        srcOk;

    assign isModem = (controlSel == dsl_pkg::CTL_MODEM);
    assign is485   = (controlSel == dsl_pkg::CTL_RS485) && PORT_HAS_485;

    dsl_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock    (clock),
        .rst      (rst),
        .inData   ({txLast, txData}),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (fOutData),
        .outValid (fOutValid),
        .outReady (fOutReady)
    );

    // ------------------------------------------------------------------------
    // Receive filtering
    // ------------------------------------------------------------------------
    assign node   = (nodeAddr > `DSL_ADDR_MAX) ? `DSL_ADDR_MAX : nodeAddr;
    assign destOk = (rxHdr.dest == node) || (selfAddrEn && rxHdr.dest == `DSL_SELF_ADDR);
    assign srcOk  = !masterValidateEn || rxHdr.src == primaryMasterAddr || rxHdr.src == masterAddr1
                    || rxHdr.src == masterAddr2 || rxHdr.src == masterAddr3
                    || rxHdr.src == masterAddr4;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxAccept <= 1'b0;
            rxDrop   <= 1'b0;
        end else begin
            rxAccept <= rxHdrValid && destOk && srcOk;
            rxDrop   <= rxHdrValid && !(destOk && srcOk);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            primaryFunc <= `DSL_FC_UNCONF;
            unsolDest   <= `DSL_DEF_MASTER;
        end else begin
            primaryFunc <= askLinkAck ? `DSL_FC_CONF_DATA : `DSL_FC_UNCONF;
            unsolDest   <= primaryMasterAddr;
        end
    end

    // ------------------------------------------------------------------------
    // Time bases, CTS synchroniser, random source
    // ------------------------------------------------------------------------
    assign msTick = (msCnt_r == 16'(CYC_PER_MS - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msCnt_r <= '0;
        end else begin
            msCnt_r <= msTick ? '0 : msCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctsSync_r   <= '0;
            ctsStable_r <= 1'b0;
        end else begin
            ctsSync_r <= {ctsSync_r[1:0], cts};
            if (ctsSync_r[1] == ctsSync_r[2]) begin
                ctsStable_r <= ctsSync_r[2];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lfsr_r <= `DSL_LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
    end

    // ------------------------------------------------------------------------
    // Half-bit divider
    // ------------------------------------------------------------------------
    always_comb begin
        case (baudSel)
            dsl_pkg::BAUD_38400: halfDiv = 16'(`DSL_CLK_HZ / (2 * 38400));
            dsl_pkg::BAUD_19200: halfDiv = 16'(`DSL_CLK_HZ / (2 * 19200));
            dsl_pkg::BAUD_9600:  halfDiv = 16'(`DSL_CLK_HZ / (2 * 9600));
            dsl_pkg::BAUD_4800:  halfDiv = 16'(`DSL_CLK_HZ / (2 * 4800));
            dsl_pkg::BAUD_2400:  halfDiv = 16'(`DSL_CLK_HZ / (2 * 2400));
            dsl_pkg::BAUD_1200:  halfDiv = 16'(`DSL_CLK_HZ / (2 * 1200));
            dsl_pkg::BAUD_600:   halfDiv = 16'(`DSL_CLK_HZ / (2 * 600));
            default:             halfDiv = 16'(`DSL_CLK_HZ / (2 * 300));
        endcase
    end

    // ------------------------------------------------------------------------
    // Character serialiser, counted in half bits so 1.5 stop bits fit.
    // ------------------------------------------------------------------------
    assign fOutReady = (state_r == ST_DRAIN) || (state_r == ST_SEND && !busy_r && !lastSent_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_r    <= '1;
            halves_r   <= '0;
            halfDiv_r  <= '0;
            bitPhase_r <= 1'b0;
            busy_r     <= 1'b0;
            lastSent_r <= 1'b0;
        end else if (state_r == ST_SEND && fOutValid && fOutReady) begin
            busy_r     <= 1'b1;
            lastSent_r <= fOutData[8];
            halfDiv_r  <= '0;
            bitPhase_r <= 1'b0;
            case (paritySel)
                dsl_pkg::PAR_EVEN: shift_r <= {1'b1, ^fOutData[7:0], fOutData[7:0], 1'b0};
                dsl_pkg::PAR_ODD:  shift_r <= {1'b1, ~^fOutData[7:0], fOutData[7:0], 1'b0};
                default:           shift_r <= {2'b11, fOutData[7:0], 1'b0};
            endcase
            halves_r <= 5'd18 + ((paritySel == dsl_pkg::PAR_NONE) ? 5'd0 : 5'd2)
                        + ((stopSel == dsl_pkg::STOP_1P5) ? 5'd3
                        : (stopSel == dsl_pkg::STOP_2) ? 5'd4 : 5'd2);
        end else if (busy_r) begin
            if (halfDiv_r == halfDiv - 1'b1) begin
                halfDiv_r  <= '0;
                bitPhase_r <= !bitPhase_r;
                halves_r   <= halves_r - 1'b1;
                if (bitPhase_r) begin
                    shift_r <= {1'b1, shift_r[10:1]};
                end
                if (halves_r == 5'd1) begin
                    busy_r <= 1'b0;
                end
            end else begin
                halfDiv_r <= halfDiv_r + 1'b1;
            end
        end else if (state_r != ST_SEND) begin
            lastSent_r <= 1'b0;
        end
    end

    assign txd      = shift_r[0];
    assign rts      = isModem && (state_r == ST_RTSUP || state_r == ST_SEND || state_r == ST_RTSOFF);
    assign driverEn = is485 && state_r == ST_SEND;
    assign txReqReady = (state_r == ST_IDLE);

    // ------------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r        <= ST_IDLE;
            waitMs_r       <= '0;
            confirmFrame_r <= 1'b0;
            retryLeft_r    <= '0;
            inRetry_r      <= 1'b0;
            frameDone      <= 1'b0;
            resendReq      <= 1'b0;
            linkFail       <= 1'b0;
        end else begin
            frameDone <= 1'b0;
            resendReq <= 1'b0;
            linkFail  <= 1'b0;
            if (msTick && waitMs_r != '0) begin
                waitMs_r <= waitMs_r - 1'b1;
            end
            case (state_r)
                ST_IDLE: begin
                    if (txReqValid) begin
                        if (txReq.secondary && !emitLinkSecondaryFrames
                            && (txReq.func == `DSL_FC_NACK || txReq.func == `DSL_FC_NOT_SUPP)) begin
                            state_r <= ST_DRAIN;
                        end else begin
                            confirmFrame_r <= !txReq.secondary && askLinkAck;
                            retryLeft_r    <= retryCount;
                            inRetry_r      <= 1'b0;
                            waitMs_r       <= 21'(preTxDelay)
                                              + 21'(is485 ? lfsr_r % (17'(maxRandomDelay) + 17'd1) : 17'd0);
                            state_r        <= ST_PRE;
                        end
                    end
                end
                ST_PRE: begin
                    if (waitMs_r == '0) begin
                        waitMs_r <= 21'(rtsSendDelay) * 21'(`DSL_UNIT_SLOW_MS);
                        state_r  <= isModem ? ST_RTSUP : ST_SEND;
                    end
                end
                ST_RTSUP: begin
                    if (waitMs_r == '0 && ctsStable_r) begin
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (lastSent_r && !busy_r) begin
                        waitMs_r <= 21'(rtsOffDelay) * 21'(`DSL_UNIT_SLOW_MS);
                        state_r  <= isModem ? ST_RTSOFF : ST_ACK;
                        if (!isModem && !confirmFrame_r) begin
                            frameDone <= 1'b1;
                            state_r   <= ST_IDLE;
                        end else if (!isModem) begin
                            waitMs_r <= 21'((ackTimeout == '0) ? 16'd1 : ackTimeout) * 21'(`DSL_UNIT_SLOW_MS);
                        end
                    end
                end
                ST_RTSOFF: begin
                    if (waitMs_r == '0) begin
                        waitMs_r <= 21'((ackTimeout == '0) ? 16'd1 : ackTimeout) * 21'(`DSL_UNIT_SLOW_MS);
                        state_r  <= confirmFrame_r ? ST_ACK : ST_IDLE;
                        frameDone <= !confirmFrame_r;
                    end
                end
                ST_ACK: begin
                    if (rxHdrValid && destOk && srcOk && rxHdr.func == `DSL_FC_ACK && !rxHdr.primary) begin
                        frameDone <= 1'b1;
                        state_r   <= ST_IDLE;
                    end else if (waitMs_r == '0) begin
                        if (retryLeft_r != '0) begin
                            retryLeft_r <= retryLeft_r - 1'b1;
                            inRetry_r   <= 1'b1;
                            resendReq   <= 1'b1;
                            waitMs_r    <= 21'(preTxDelay);
                            state_r     <= ST_PRE;
                        end else begin
                            linkFail <= 1'b1;
                            state_r  <= ST_IDLE;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (fOutValid && fOutData[8]) begin
                        frameDone <= 1'b1;
                        state_r   <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule : dsl_serial_link

/* verification/dsl_link_checker.sv */
`timescale 1ns/10ps
`include "dsl_defs.svh"
module dsl_link_checker (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic [15:0]           nodeAddr,
    input wire dsl_pkg::dsl_control_t controlSel,
    input wire logic                  masterValidateEn,
    input wire logic                  selfAddrEn,
    input wire logic [15:0]           primaryMasterAddr,
    input wire logic                  askLinkAck,
    input wire dsl_pkg::dsl_rx_hdr_t  rxHdr,
    input wire logic                  rxHdrValid,
    input wire logic                  rxAccept,
    input wire logic                  rxDrop,
    input wire logic [3:0]            primaryFunc,
    input wire logic [15:0]           unsolDest,
    input wire logic                  txd,
    input wire logic                  rts,
    input wire logic                  driverEn,
    input wire logic                  cts
);
    logic        run_r;
    logic [15:0] lastMaster_r;
    logic        lastAsk_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
        end else begin
            run_r <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        lastMaster_r <= primaryMasterAddr;
        lastAsk_r    <= askLinkAck;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_RX_ANSWER: assert property (rxHdrValid |=> rxAccept != rxDrop)
        else $error("no single filter answer");
    AST_RX_QUIET: assert property (!rxHdrValid |=> !rxAccept && !rxDrop)
        else $error("filter answer without header");
    AST_SELF_DROP: assert property (rxHdrValid && rxHdr.dest == `DSL_SELF_ADDR && !selfAddrEn |=> rxDrop)
        else $error("self address taken while off");
    AST_FOREIGN_DROP: assert property (rxHdrValid && rxHdr.dest != nodeAddr && rxHdr.dest != `DSL_SELF_ADDR
        |=> rxDrop) else $error("foreign frame taken");
    AST_ANY_MASTER: assert property (rxHdrValid && !masterValidateEn && rxHdr.dest == nodeAddr
        && nodeAddr <= `DSL_ADDR_MAX |=> rxAccept) else $error("own frame dropped");
    AST_UNSOL_DEST: assert property (run_r |-> unsolDest == lastMaster_r)
        else $error("unsolicited destination wrong");
    AST_FUNC_CODE: assert property (run_r |-> primaryFunc == (lastAsk_r ? `DSL_FC_CONF_DATA : `DSL_FC_UNCONF))
        else $error("primary function code wrong");
    AST_MODEM_START: assert property ($fell(txd) && controlSel == dsl_pkg::CTL_MODEM |-> rts && $past(cts, 4))
        else $error("modem start without handshake");
    AST_NO_HANDSHAKE: assert property (controlSel == dsl_pkg::CTL_NONE |-> !rts && !driverEn)
        else $error("handshake line active in plain mode");
endmodule : dsl_link_checker

bind dsl_serial_link dsl_link_checker dsl_link_checker_inst (.clock, .rst, .nodeAddr, .controlSel,
    .masterValidateEn, .selfAddrEn, .primaryMasterAddr, .askLinkAck, .rxHdr, .rxHdrValid, .rxAccept,
    .rxDrop, .primaryFunc, .unsolDest, .txd, .rts, .driverEn, .cts);

/* verification/dsl_master_model.sv */
`timescale 1ns/10ps
module dsl_master_model #(
    parameter int BIT_CYC = 1302
) (
    input  wire logic        clock,
    input  wire logic        txd,
    input  wire logic        rts,
    input  wire logic        ctsSlow,
    output logic             cts,
    output logic      [31:0] rxWord,
    output int               rxCount
);
    logic [7:0] lag_r = 8'h00;
    logic [7:0] bits;
    always @(posedge clock) begin
        lag_r <= {lag_r[6:0], rts};
    end
    // The modem answers after a short or long lag and drops its answer with the request.
    assign cts = rts && (ctsSlow ? lag_r[7] : lag_r[1]);
    initial begin
        rxWord = '0;
        rxCount = 0;
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge clock);
            if (txd == 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge clock);
                    bits[i] = txd;
                end
                repeat (BIT_CYC) @(posedge clock);
                rxWord = {rxWord[23:0], bits};
                rxCount++;
            end
        end
    end
endmodule : dsl_master_model

/* verification/tb_top.sv */
`timescale 1ns/10ps
`include "dsl_defs.svh"
module tb_top;
    logic clock = 1'b0, rst = 1'b1;
    logic [15:0] nodeAddr = 16'h0123, primaryMasterAddr = 16'h0040;
    logic [15:0] masterAddr1 = 16'h0041, masterAddr2 = 16'h0042, masterAddr3 = 16'h0043, masterAddr4 = 16'h0044;
    dsl_pkg::dsl_control_t controlSel = dsl_pkg::CTL_NONE;
    logic masterValidateEn = 0, selfAddrEn = 0, askLinkAck = 0, emitLinkSecondaryFrames = 0, ctsSlow = 0;
    logic [15:0] ackTimeout = 16'h0004, preTxDelay = 16'h0000, maxRandomDelay = 16'h0000;
    logic [15:0] rtsOffDelay = 16'h0001, rtsSendDelay = 16'h0001;
    logic [7:0] retryCount = 8'h00, txData = 8'h00;
    dsl_pkg::dsl_rx_hdr_t rxHdr = '0;
    dsl_pkg::dsl_tx_req_t txReq = '0;
    logic rxHdrValid = 0, txReqValid = 0, txValid = 0, txLast = 0, flag;
    logic rxAccept, rxDrop, txReqReady, txReady, frameDone, resendReq, linkFail, txd, rts, driverEn, cts;
    logic [3:0] primaryFunc;
    logic [15:0] unsolDest;
    logic [31:0] rxWord;
    logic [2:0] ev;
    int rxCount, base, falls = 0, err_total = 0, n_compared = 0;
    always #10 clock = ~clock;
    always @(negedge txd) falls++;
    dsl_serial_link #(.CYC_PER_MS(10), .PORT_HAS_485(1'b1), .FIFO_DEPTH(4)) dsl_serial_link_inst (
        .clock, .rst, .nodeAddr, .baudSel(dsl_pkg::BAUD_38400), .paritySel(dsl_pkg::PAR_NONE),
        .stopSel(dsl_pkg::STOP_1), .controlSel, .masterValidateEn, .selfAddrEn, .primaryMasterAddr, .masterAddr1,
        .masterAddr2, .masterAddr3, .masterAddr4, .askLinkAck, .emitLinkSecondaryFrames, .ackTimeout, .retryCount,
        .preTxDelay, .maxRandomDelay, .rtsOffDelay, .rtsSendDelay, .rxHdr, .rxHdrValid, .rxAccept, .rxDrop, .txReq,
        .txReqValid, .txReqReady, .txData, .txLast, .txValid, .txReady, .primaryFunc, .unsolDest, .frameDone,
        .resendReq, .linkFail, .txd, .rts, .driverEn, .cts);
    dsl_master_model dsl_master_model_inst (.clock, .txd, .rts, .ctsSlow, .cts, .rxWord, .rxCount);
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_evt(input int lim);
        ev = 3'b000;
        for (int i = 0; i < lim && ev == 3'b000; i++) begin
            tick();
            ev = {linkFail, resendReq, frameDone};
        end
        if (ev == 3'b000) begin
            chk(ev, 3'b111);
            end_of_test();
        end
    endtask : wait_evt
    task automatic wait_rx(input int n);
        for (int i = 0; i < 40000 && rxCount < n; i++) tick();
        chk(rxCount >= n, 1'b1);
        if (rxCount < n) end_of_test();
    endtask : wait_rx
    task automatic send_req(input logic sec, input logic [3:0] fn);
        txReq = '{sec, fn};
        txReqValid = 1'b1;
        tick();
        txReqValid = 1'b0;
    endtask : send_req
    task automatic push(input logic [7:0] b, input logic last);
        for (int i = 0; i < 100 && (i == 0 || !txReady); i++) tick();
        if (!txReady) wait_evt(0);
        txData = b;
        txLast = last;
        txValid = 1'b1;
        tick();
        txValid = 1'b0;
        txLast = 1'b0;
    endtask : push
    task automatic s_reset();
        chk({txd, rts, driverEn, txReqReady, txReady}, 5'b10011);
        chk(unsolDest, 16'h0040);
        chk(primaryFunc, `DSL_FC_UNCONF);
        askLinkAck = 1'b1;
        primaryMasterAddr = 16'h0ABC;
        tick(2);
        chk(primaryFunc, `DSL_FC_CONF_DATA);
        chk(unsolDest, 16'h0ABC);
        askLinkAck = 1'b0;
        primaryMasterAddr = 16'h0040;
        tick(2);
    endtask : s_reset
    task automatic s_filter();
        logic [15:0] dTab [8] = '{16'h0123, 16'h0124, 16'hFFFC, 16'hFFFC, 16'h0123, 16'h0123, 16'h0123, 16'h0123};
        logic [15:0] sTab [8] = '{16'h0999, 16'h0040, 16'h0040, 16'h0040, 16'h0044, 16'h0041, 16'h0045, 16'h0040};
        logic [2:0] fTab [8] = '{3'b001, 3'b000, 3'b000, 3'b011, 3'b101, 3'b101, 3'b100, 3'b101};
        rxHdrValid = 1'b1;
        for (int i = 0; i < 8; i++) begin
            {masterValidateEn, selfAddrEn} = fTab[i][2:1];
            rxHdr = '{dTab[i], sTab[i], 4'h3, 1'b1};
            tick();
            chk({rxAccept, rxDrop}, {fTab[i][0], !fTab[i][0]});
        end
        rxHdrValid = 1'b0;
        {masterValidateEn, selfAddrEn} = 2'b00;
    endtask : s_filter
    task automatic s_fill();
        controlSel = dsl_pkg::CTL_RS485;
        {preTxDelay, maxRandomDelay} = {16'h0005, 16'h0003};
        base = rxCount;
        send_req(1'b0, `DSL_FC_UNCONF);
        for (int i = 0; i < 4; i++) push(8'hA5 - 8'h33 * i, i == 3);
        chk(txReady, 1'b0);
        flag = 1'b0;
        repeat (34) begin
            tick();
            flag |= !txd;
        end
        chk(flag, 1'b0);
        tick(60);
        chk(driverEn, 1'b1);
        wait_evt(60000);
        chk({ev, rxCount - base}, {3'b001, 32'd4});
        chk(rxWord, 32'hA572_3F0C);
        controlSel = dsl_pkg::CTL_NONE;
        {preTxDelay, maxRandomDelay} = 32'h0000_0000;
    endtask : s_fill
    task automatic s_secondary(input logic [3:0] fn);
        base = falls;
        send_req(1'b1, fn);
        push(8'h55, 1'b0);
        push(8'hAA, 1'b1);
        wait_evt(3000);
        chk({ev, falls - base}, {3'b001, 32'd0});
    endtask : s_secondary
    task automatic s_retry();
        controlSel = dsl_pkg::CTL_MODEM;
        {ctsSlow, askLinkAck, retryCount, ackTimeout} = {1'b1, 1'b1, 8'h01, 16'h0001};
        base = rxCount;
        send_req(1'b0, `DSL_FC_CONF_DATA);
        push(8'h3C, 1'b1);
        for (int i = 0; i < 100 && !rts; i++) tick();
        flag = 1'b0;
        repeat (180) begin
            tick();
            flag |= !txd;
        end
        chk({rts, flag}, 2'b10);
        wait_rx(base + 1);
        tick(800);
        chk(rts, 1'b1);
        wait_evt(2000);
        chk({ev, rts, rxWord[7:0]}, {3'b010, 1'b0, 8'h3C});
        push(8'h3C, 1'b1);
        wait_evt(40000);
        chk({ev, rxCount - base}, {3'b100, 32'd2});
        controlSel = dsl_pkg::CTL_NONE;
        {ctsSlow, retryCount, ackTimeout} = {1'b0, 8'h00, 16'h0004};
    endtask : s_retry
    task automatic s_ack();
        base = rxCount;
        send_req(1'b0, `DSL_FC_CONF_DATA);
        push(8'h81, 1'b1);
        wait_rx(base + 1);
        tick(1000);
        rxHdr = '{16'h0123, 16'h0040, `DSL_FC_ACK, 1'b0};
        rxHdrValid = 1'b1;
        wait_evt(2000);
        rxHdrValid = 1'b0;
        chk(ev, 3'b001);
    endtask : s_ack
    initial begin
        tick(4);
        rst = 1'b0;
        tick(2);
        s_reset();
        s_filter();
        s_fill();
        s_secondary(`DSL_FC_NACK);
        s_secondary(`DSL_FC_NOT_SUPP);
        s_retry();
        s_ack();
        end_of_test();
    end
endmodule : tb_top
